// file: logic/oad_pkg.sv
/*
 * constants for the operand address decoder: field positions, opcode
 * groups, address modes and size scaling.
 * assumes a 16-bit fixed instruction word and a 32-bit register datapath.
 */
// Functional notes
// - register plus zero-extended scaled 4-bit displacement
// - register plus register zero, unscaled
// - global base plus zero-extended scaled 8-bit displacement
// - global base plus register zero, unscaled
// - zero-extend immediate for test and logic ops
// - sign-extend immediate for move, add, compare
// - trap immediate zero-extended, times four
// - multiply-accumulate: both fields post-increment sources
// - single-source format: source in bits 11..8
// - opcode selects each register field role
package oad_pkg;
    localparam int OAD_OP_HI = 15;
    localparam int OAD_OP_LO = 12;
    localparam int OAD_RN_HI = 11;
    localparam int OAD_RN_LO = 8;
    localparam int OAD_RM_HI = 7;
    localparam int OAD_RM_LO = 4;
    localparam int OAD_D4_HI = 3;
    localparam int OAD_D8_HI = 7;
    localparam int OAD_D12_HI = 11;
    localparam logic [3:0] OAD_REG_ZERO = 4'h0;
    localparam logic [1:0] OAD_SZ_BYTE = 2'h0;
    localparam logic [1:0] OAD_SZ_WORD = 2'h1;
    localparam logic [1:0] OAD_SZ_LONG = 2'h2;
    localparam logic [1:0] OAD_TRAP_SHIFT = 2'h2;
    // top-nibble opcode groups
    localparam logic [3:0] OAD_GRP_MISC = 4'h0;
    localparam logic [3:0] OAD_GRP_ST_DISP = 4'h1;
    localparam logic [3:0] OAD_GRP_ST_IND = 4'h2;
    localparam logic [3:0] OAD_GRP_ARITH = 4'h3;
    localparam logic [3:0] OAD_GRP_SYS = 4'h4;
    localparam logic [3:0] OAD_GRP_LD_DISP = 4'h5;
    localparam logic [3:0] OAD_GRP_LD_IND = 4'h6;
    localparam logic [3:0] OAD_GRP_ADD_IMM = 4'h7;
    localparam logic [3:0] OAD_GRP_SHORT = 4'h8;
    localparam logic [3:0] OAD_GRP_PCW = 4'h9;
    localparam logic [3:0] OAD_GRP_BRA = 4'ha;
    localparam logic [3:0] OAD_GRP_BSR = 4'hb;
    localparam logic [3:0] OAD_GRP_GBR = 4'hc;
    localparam logic [3:0] OAD_GRP_PCL = 4'hd;
    localparam logic [3:0] OAD_GRP_MOV_IMM = 4'he;
    // second nibble selectors: trap and mova in group 0xc, compare in group 0x8
    localparam logic [3:0] OAD_C_TRAP = 4'h3;
    localparam logic [3:0] OAD_C_MOVA = 4'h7;
    localparam logic [3:0] OAD_C_CMPEQ_SUB = 4'h8;
    // field roles
    typedef enum logic [2:0] {
        OAD_FLD_NONE = 3'h0,
        OAD_FLD_DIRECT = 3'h1,
        OAD_FLD_INDIRECT = 3'h3,
        OAD_FLD_POSTINC = 3'h2,
        OAD_FLD_PREDEC = 3'h6,
        OAD_FLD_INDEXED = 3'h7,
        OAD_FLD_DISP = 3'h5
    } oad_fld_e;
    // effective address kinds
    typedef enum logic [2:0] {
        OAD_EA_NONE = 3'h0,
        OAD_EA_REG_DISP = 3'h1,
        OAD_EA_REG_IDX = 3'h3,
        OAD_EA_GBR_DISP = 3'h2,
        OAD_EA_GBR_IDX = 3'h6,
        OAD_EA_PC_DISP = 3'h7,
        OAD_EA_REG = 3'h5
    } oad_ea_e;
    typedef enum logic [1:0] {
        OAD_IMM_NONE = 2'h0,
        OAD_IMM_ZERO = 2'h1,
        OAD_IMM_SIGN = 2'h3,
        OAD_IMM_TRAP = 2'h2
    } oad_imm_e;
endpackage

// file: logic/oad_operand_address_decoder.sv
/*
 * operand address decoder: registered decode of one instruction word per
 * valid cycle into field roles, immediate and effective address.
 * assumes register values arrive from the register file on the same clock
 * in the cycle the word is presented.
 */
`timescale 1ns/1ps
module oad_operand_address_decoder
    import oad_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic sys_clk_i, // core clock
    input wire logic nrst_i, // async reset, active low
    input wire logic instr_valid_i, // instruction word present
    input wire logic [15:0] instr_i, // instruction word
    input wire logic [DATA_W-1:0] dest_general_register_i, // field 11..8 value
    input wire logic [DATA_W-1:0] source_general_register_i, // field 7..4
    input wire logic [DATA_W-1:0] register_zero_i, // register zero value
    input wire logic [DATA_W-1:0] global_base_register_i, // global base value
    input wire logic [DATA_W-1:0] pc_i, // address of this instruction
    output logic out_valid_o, // decode result valid
    output logic [3:0] opcode_o, // top nibble
    output logic [3:0] dest_field_o, // register number in 11..8
    output logic [3:0] src_field_o, // register number in 7..4
    output logic [2:0] dest_role_o, // oad_fld_e for dest field
    output logic [2:0] src_role_o, // oad_fld_e for source field
    output logic [1:0] size_o, // byte, word, long
    output logic [2:0] ea_kind_o, // oad_ea_e
    output logic [DATA_W-1:0] ea_o, // effective address
    output logic [1:0] imm_kind_o, // oad_imm_e
    output logic [DATA_W-1:0] imm_o, // extended immediate
    output logic [DATA_W-1:0] branch_disp_o, // sign-extended branch disp; zero-extended 8-bit disp for pc loads
    output logic mac_dest_o, // result goes to accumulator pair
    output logic ctrl_dest_o // dest is control or system register
);
    typedef struct packed {
        logic valid;
        logic [3:0] op;
        logic [3:0] rn;
        logic [3:0] rm;
        oad_fld_e rn_role;
        oad_fld_e rm_role;
        logic [1:0] size;
        oad_ea_e ea_kind;
        logic [DATA_W-1:0] ea;
        oad_imm_e imm_kind;
        logic [DATA_W-1:0] imm;
        logic [DATA_W-1:0] bdisp;
        logic mac;
        logic ctrl;
    } oad_state_s;

    oad_state_s st;
    oad_state_s next_st;

    // displacement times 1/2/4, zero-extended
    function automatic logic [DATA_W-1:0] scale_disp(
        input logic [7:0] d, input logic [1:0] sz);
        logic [DATA_W-1:0] z;
        z = DATA_W'(d);
        case (sz)
            OAD_SZ_WORD: scale_disp = z << 1;
            OAD_SZ_LONG: scale_disp = z << 2;
            default: scale_disp = z;
        endcase
    endfunction

    always_comb begin
        logic [15:0] w;
        logic [3:0] lo;
        w = instr_i;
        lo = w[3:0];
        next_st = st;
        next_st.valid = instr_valid_i;
        if (instr_valid_i) begin
            next_st.op = w[OAD_OP_HI:OAD_OP_LO];
            next_st.rn = w[OAD_RN_HI:OAD_RN_LO];
            next_st.rm = w[OAD_RM_HI:OAD_RM_LO];
            next_st.rn_role = OAD_FLD_NONE;
            next_st.rm_role = OAD_FLD_NONE;
            next_st.size = OAD_SZ_LONG;
            next_st.ea_kind = OAD_EA_NONE;
            next_st.ea = '0;
            next_st.imm_kind = OAD_IMM_NONE;
            next_st.imm = '0;
            next_st.bdisp = '0;
            next_st.mac = 1'b0;
            next_st.ctrl = 1'b0;
            case (w[OAD_OP_HI:OAD_OP_LO])
                OAD_GRP_MISC: begin
                    if (lo == 4'hf) begin
                        next_st.rn_role = OAD_FLD_POSTINC;
                        next_st.rm_role = OAD_FLD_POSTINC;
                        next_st.mac = 1'b1;
                        next_st.size = OAD_SZ_WORD;
                    end else if (lo[3:2] == 2'h1 || lo[3:2] == 2'h3) begin
                        next_st.size = lo[1:0];
                        next_st.ea_kind = OAD_EA_REG_IDX;
                        next_st.ea = (lo[3:2] == 2'h1) ?
                            dest_general_register_i + register_zero_i :
                            source_general_register_i + register_zero_i;
                        next_st.rn_role = (lo[3:2] == 2'h1) ?
                            OAD_FLD_INDEXED : OAD_FLD_DIRECT;
                        next_st.rm_role = (lo[3:2] == 2'h1) ?
                            OAD_FLD_DIRECT : OAD_FLD_INDEXED;
                    end else begin
                        next_st.rn_role = OAD_FLD_DIRECT;
                    end
                end
                OAD_GRP_ST_DISP, OAD_GRP_LD_DISP: begin
                    next_st.size = OAD_SZ_LONG;
                    next_st.ea_kind = OAD_EA_REG_DISP;
                    next_st.ea = ((w[OAD_OP_HI:OAD_OP_LO] == OAD_GRP_ST_DISP)
                        ? dest_general_register_i : source_general_register_i)
                        + scale_disp({4'h0, w[OAD_D4_HI:0]}, OAD_SZ_LONG);
                    next_st.rn_role = (w[OAD_OP_HI:OAD_OP_LO] ==
                        OAD_GRP_ST_DISP) ? OAD_FLD_DISP : OAD_FLD_DIRECT;
                    next_st.rm_role = (w[OAD_OP_HI:OAD_OP_LO] ==
                        OAD_GRP_ST_DISP) ? OAD_FLD_DIRECT : OAD_FLD_DISP;
                end
                OAD_GRP_ST_IND: begin
                    next_st.size = lo[1:0];
                    next_st.ea_kind = OAD_EA_REG;
                    next_st.rn_role = lo[2] ? OAD_FLD_PREDEC
                                            : OAD_FLD_INDIRECT;
                    next_st.rm_role = OAD_FLD_DIRECT;
                    next_st.ea = dest_general_register_i;
                    if (lo == 4'hf) begin
                        next_st.mac = 1'b1;
                        next_st.rn_role = OAD_FLD_POSTINC;
                        next_st.rm_role = OAD_FLD_POSTINC;
                        next_st.ea_kind = OAD_EA_NONE;
                        next_st.ea = '0;
                    end
                end
                OAD_GRP_LD_IND: begin
                    next_st.size = lo[1:0];
                    next_st.ea_kind = OAD_EA_REG;
                    next_st.ea = source_general_register_i;
                    next_st.rn_role = OAD_FLD_DIRECT;
                    next_st.rm_role = lo[2] ? OAD_FLD_POSTINC
                                            : OAD_FLD_INDIRECT;
                end
                OAD_GRP_ARITH: begin
                    next_st.rn_role = OAD_FLD_DIRECT;
                    next_st.rm_role = OAD_FLD_DIRECT;
                end
                OAD_GRP_SYS: begin
                    // single-source load of control/system register
                    next_st.rn_role = (w[3:0] == 4'he || w[3:0] == 4'ha) ?
                        OAD_FLD_DIRECT : OAD_FLD_POSTINC;
                    next_st.ctrl = w[1];
                    next_st.ea = dest_general_register_i;
                end
                OAD_GRP_ADD_IMM, OAD_GRP_MOV_IMM: begin
                    next_st.rn_role = OAD_FLD_DIRECT;
                    next_st.imm_kind = OAD_IMM_SIGN;
                    next_st.imm = DATA_W'($signed(w[OAD_D8_HI:0]));
                end
                OAD_GRP_SHORT: begin
                    if (w[11:10] == 2'h0) begin
                        // short displacement forms use register zero
                        next_st.size = w[9:8];
                        next_st.ea_kind = OAD_EA_REG_DISP;
                        next_st.rm_role = OAD_FLD_DISP;
                        next_st.ea = source_general_register_i +
                            scale_disp({4'h0, w[OAD_D4_HI:0]},
                                       w[9:8]);
                    end else if (w[11:8] == OAD_C_CMPEQ_SUB) begin
                        next_st.imm_kind = OAD_IMM_SIGN;
                        next_st.imm = DATA_W'($signed(w[OAD_D8_HI:0]));
                    end else begin
                        // conditional branch: 8-bit pc-relative
                        next_st.bdisp =
                            DATA_W'($signed(w[OAD_D8_HI:0]));
                    end
                end
                OAD_GRP_BRA, OAD_GRP_BSR: begin
                    next_st.bdisp =
                        DATA_W'($signed(w[OAD_D12_HI:0]));
                end
                OAD_GRP_PCW, OAD_GRP_PCL: begin
                    next_st.rn_role = OAD_FLD_DIRECT;
                    next_st.size = (w[OAD_OP_HI:OAD_OP_LO] == OAD_GRP_PCW) ?
                        OAD_SZ_WORD : OAD_SZ_LONG;
                    next_st.ea_kind = OAD_EA_PC_DISP;
                    next_st.bdisp = DATA_W'(w[OAD_D8_HI:0]);
                    next_st.ea = pc_i + scale_disp(w[OAD_D8_HI:0],
                                                   next_st.size);
                end
                OAD_GRP_GBR: begin
                    next_st.size = w[9:8];
                    if (w[11:8] == OAD_C_TRAP) begin
                        next_st.imm_kind = OAD_IMM_TRAP;
                        next_st.imm = DATA_W'(w[OAD_D8_HI:0]) <<
                            OAD_TRAP_SHIFT;
                    end else if (w[11:8] == OAD_C_MOVA) begin
                        next_st.ea_kind = OAD_EA_PC_DISP;
                        next_st.ea = pc_i +
                            scale_disp(w[OAD_D8_HI:0], OAD_SZ_LONG);
                    end else if (w[11] == 1'b1) begin
                        // test, and, xor, or: immediate zero-extended
                        next_st.imm_kind = OAD_IMM_ZERO;
                        next_st.imm = DATA_W'(w[OAD_D8_HI:0]);
                        if (w[10]) begin
                            next_st.size = OAD_SZ_BYTE;
                            next_st.ea_kind = OAD_EA_GBR_IDX;
                            next_st.ea = global_base_register_i +
                                register_zero_i;
                        end
                    end else if (w[9:8] != 2'h3) begin
                        next_st.ea_kind = OAD_EA_GBR_DISP;
                        next_st.ea = global_base_register_i +
                            scale_disp(w[OAD_D8_HI:0], w[9:8]);
                    end
                end
                default: begin
                    next_st.rn_role = OAD_FLD_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out_valid_o = st.valid;
    assign opcode_o = st.op;
    assign dest_field_o = st.rn;
    assign src_field_o = st.rm;
    assign dest_role_o = st.rn_role;
    assign src_role_o = st.rm_role;
    assign size_o = st.size;
    assign ea_kind_o = st.ea_kind;
    assign ea_o = st.ea;
    assign imm_kind_o = st.imm_kind;
    assign imm_o = st.imm;
    assign branch_disp_o = st.bdisp;
    assign mac_dest_o = st.mac;
    assign ctrl_dest_o = st.ctrl;
endmodule // oad_operand_address_decoder

// file: dv/oad_regfile_model.sv
/* register file model for the decoder: serves operand values for the
   fields of the word on the bus, on the same clock as the word. */
`timescale 1ns/1ps
module oad_regfile_model #(
    parameter logic [31:0] BASE_VAL = 32'h0000_1000
) (
    input wire logic [15:0] instr_i, // word being presented
    output logic [31:0] dest_val_o, // register at 11..8
    output logic [31:0] src_val_o, // register at 7..4
    output logic [31:0] zero_val_o, // register zero
    output logic [31:0] base_val_o // global base register
);
    // each register but the global base holds a value naming it, so a wrong pick shows
    assign dest_val_o = {16'h0001, instr_i[11:8], 12'h000} >> 4;
    assign src_val_o = {16'h0001, instr_i[7:4], 12'h000} >> 4;
    assign zero_val_o = 32'h0000_1000;
    assign base_val_o = BASE_VAL;
endmodule // oad_regfile_model

// file: dv/oad_monitor.sv
/* checker on the decoder ports.
   assumes one clock and the low-active reset of the decoder. */
`timescale 1ns/1ps
module oad_monitor
    import oad_pkg::*;
(
    input wire logic sys_clk_i, // clock
    input wire logic nrst_i, // reset
    input wire logic instr_valid_i, // word present
    input wire logic [15:0] instr_i, // word
    input wire logic [31:0] register_zero_i, // register zero
    input wire logic [31:0] global_base_register_i, // base
    input wire logic out_valid_o, // result valid
    input wire logic [3:0] opcode_o, // opcode
    input wire logic [2:0] dest_role_o, // dest role
    input wire logic [2:0] src_role_o, // source role
    input wire logic [1:0] size_o, // size
    input wire logic [2:0] ea_kind_o, // ea kind
    input wire logic [31:0] ea_o, // address
    input wire logic [1:0] imm_kind_o, // imm kind
    input wire logic [31:0] imm_o, // immediate
    input wire logic mac_dest_o // accumulator dest
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    result_timing_a: assert property (1 |=>
        out_valid_o == $past(instr_valid_i)
        && (!out_valid_o || opcode_o == $past(instr_i[15:12])))
        else $error("result not one cycle after word");
    idle_hold_a: assert property (!instr_valid_i |=> $stable(ea_o)
        && $stable(imm_o)) else $error("outputs moved while idle");
    gbr_disp_a: assert property (out_valid_o
        && ea_kind_o == OAD_EA_GBR_DISP
        |-> ea_o == $past(global_base_register_i)
        + ({24'h0, $past(instr_i[7:0])} << size_o)) else $error("gbr disp");
    gbr_index_a: assert property (out_valid_o
        && ea_kind_o == OAD_EA_GBR_IDX
        |-> ea_o == $past(global_base_register_i)
        + $past(register_zero_i)) else $error("gbr index");
    zero_imm_a: assert property (out_valid_o
        && imm_kind_o == OAD_IMM_ZERO
        |-> imm_o == {24'h0, $past(instr_i[7:0])})
        else $error("zero-extended immediate");
    sign_imm_a: assert property (out_valid_o
        && imm_kind_o == OAD_IMM_SIGN
        |-> imm_o == {{24{$past(instr_i[7])}}, $past(instr_i[7:0])})
        else $error("sign-extended immediate");
    trap_imm_a: assert property (out_valid_o
        && imm_kind_o == OAD_IMM_TRAP
        |-> imm_o == {22'h0, $past(instr_i[7:0]), 2'h0})
        else $error("trap immediate");
    mac_roles_a: assert property (out_valid_o && mac_dest_o |->
        src_role_o == OAD_FLD_POSTINC && dest_role_o == OAD_FLD_POSTINC)
        else $error("accumulate roles");
endmodule // oad_monitor
bind oad_operand_address_decoder oad_monitor u_mon (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .register_zero_i(register_zero_i),
    .global_base_register_i(global_base_register_i),
    .out_valid_o(out_valid_o), .opcode_o(opcode_o), .dest_role_o(dest_role_o),
    .src_role_o(src_role_o), .size_o(size_o), .ea_kind_o(ea_kind_o),
    .ea_o(ea_o), .imm_kind_o(imm_kind_o), .imm_o(imm_o),
    .mac_dest_o(mac_dest_o));

// file: dv/test_operand_address_decoder.sv
/* self-checking bench for the operand address decoder.
   assumes the register file model feeds operand values combinationally. */
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error t=%0t got=%h exp=%h", $time, a, e); end end
module test_operand_address_decoder
    import oad_pkg::*;
;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [31:0] rn_v, rm_v, r0_v, gbr_v, ea_o, imm_o, branch_disp_o;
    logic [3:0] opcode_o, dest_field_o, src_field_o;
    logic [2:0] dest_role_o, src_role_o, ea_kind_o;
    logic [1:0] size_o, imm_kind_o;
    logic out_valid_o, mac_dest_o, ctrl_dest_o;
    int error_cnt = 0, check_count = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    oad_regfile_model model (.instr_i(instr_i), .dest_val_o(rn_v),
        .src_val_o(rm_v), .zero_val_o(r0_v), .base_val_o(gbr_v));
    oad_operand_address_decoder dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .dest_general_register_i(rn_v), .source_general_register_i(rm_v),
        .register_zero_i(r0_v), .global_base_register_i(gbr_v),
        .pc_i(32'h0000_2000), .out_valid_o(out_valid_o), .opcode_o(opcode_o),
        .dest_field_o(dest_field_o), .src_field_o(src_field_o),
        .dest_role_o(dest_role_o), .src_role_o(src_role_o), .size_o(size_o),
        .ea_kind_o(ea_kind_o), .ea_o(ea_o), .imm_kind_o(imm_kind_o),
        .imm_o(imm_o), .branch_disp_o(branch_disp_o),
        .mac_dest_o(mac_dest_o), .ctrl_dest_o(ctrl_dest_o));
    function automatic logic [31:0] rv(input logic [3:0] k);
        return {20'h00001, k, 8'h00};
    endfunction
    task automatic send(input logic [15:0] w);
        @(negedge sys_clk_i);
        instr_i = w;
        instr_valid_i = 1'b1;
        @(negedge sys_clk_i);
        instr_valid_i = 1'b0;
        `CHK(out_valid_o, 1'b1)
    endtask
    task automatic t_reg_disp();
        send(16'h8123);
        `CHK(ea_kind_o, OAD_EA_REG_DISP)
        `CHK(ea_o, rv(4'h2) + 32'h6)
        `CHK(size_o, OAD_SZ_WORD)
        send(16'h1473);
        `CHK(ea_o, rv(4'h4) + 32'hc)
        send(16'h5473);
        `CHK(ea_o, rv(4'h7) + 32'hc)
    endtask
    task automatic t_indexed();
        send(16'h034c);
        `CHK(ea_kind_o, OAD_EA_REG_IDX)
        `CHK(ea_o, rv(4'h4) + 32'h0000_1000)
        send(16'hc510);
        `CHK(ea_kind_o, OAD_EA_GBR_DISP)
        `CHK(ea_o, 32'h0000_1020)
        `CHK(size_o, OAD_SZ_WORD)
        send(16'hcd05);
        `CHK(ea_kind_o, OAD_EA_GBR_IDX)
        `CHK(ea_o, 32'h0000_2000)
    endtask
    task automatic t_imm_branch();
        send(16'hc880);
        `CHK(imm_o, 32'h0000_0080)
        send(16'he480);
        `CHK(imm_o, 32'hffff_ff80)
        send(16'hc3ff);
        `CHK(imm_o, 32'h0000_03fc)
        `CHK(imm_kind_o, OAD_IMM_TRAP)
        send(16'hd305);
        `CHK(ea_o, 32'h0000_2014)
        `CHK(branch_disp_o, 32'h0000_0005)
        send(16'ha801);
        `CHK(branch_disp_o, 32'hffff_f801)
        send(16'h8b80);
        `CHK(branch_disp_o, 32'hffff_ff80)
    endtask
    task automatic t_roles();
        send(16'h034f);
        `CHK(mac_dest_o, 1'b1)
        `CHK(src_role_o, OAD_FLD_POSTINC)
        `CHK(dest_role_o, OAD_FLD_POSTINC)
        `CHK({dest_field_o, src_field_o}, 8'h34)
        send(16'h430e);
        `CHK(ctrl_dest_o, 1'b1)
        `CHK(dest_role_o, OAD_FLD_DIRECT)
        `CHK({opcode_o, dest_field_o}, 8'h43)
    endtask
    // back to back words, then an idle cycle that must hold the result
    task automatic t_b2b_hold();
        @(negedge sys_clk_i);
        instr_i = 16'hc880;
        instr_valid_i = 1'b1;
        @(negedge sys_clk_i);
        instr_i = 16'he480;
        `CHK(imm_o, 32'h0000_0080)
        @(negedge sys_clk_i);
        instr_valid_i = 1'b0;
        instr_i = 16'hc3ff;
        `CHK(imm_o, 32'hffff_ff80)
        @(negedge sys_clk_i);
        `CHK({out_valid_o, imm_o}, 33'h0_ffff_ff80)
        // mid-run reset must clear the held result, then decode resumes
        nrst_i = 1'b0;
        @(negedge sys_clk_i);
        `CHK({out_valid_o, imm_o, ea_o}, 65'h0)
        nrst_i = 1'b1;
        send(16'hc3ff);
        `CHK(imm_o, 32'h0000_03fc)
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #(2000 * 100);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (3) @(negedge sys_clk_i);
        `CHK({out_valid_o, ea_o}, 33'h0)
        nrst_i = 1'b1;
        t_reg_disp();
        t_indexed();
        t_imm_branch();
        t_roles();
        t_b2b_hold();
        final_report();
    end
endmodule // test_operand_address_decoder
